// file: logic/uwcp_pkg.sv
// Constants and carriers for the USB host wake and clock power control block
package uwcp_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] PSTATE_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] OPWRITE_OFFSET = 8'h0c;
    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] PSTATE_RESET = 32'h0000_0040;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Power states of a core
    localparam logic [1:0] PS_D0 = 2'h0;
    // Legacy core functional states
    localparam logic [1:0] LFS_RESET = 2'h0;
    localparam logic [1:0] LFS_RESUME = 2'h1;
    localparam logic [1:0] LFS_OPER = 2'h2;
    localparam logic [1:0] LFS_SUSPEND = 2'h3;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int WAKE_HOLD_NS = 1600;
    localparam int WAKE_HOLD_CYC = (WAKE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] CLKRUN_HOLD_EDGES = 2'h2;

    // Software controlled enables
    typedef struct packed {
        logic [19:0] rsvd;
        logic legacy_bus_master;
        logic enh_run;
        logic port_change_irq_enable;
        logic enh_event_output_enable;
        logic overcurrent_wake_enable;
        logic disconnect_wake_enable;
        logic connect_wake_enable;
        logic hub_status_change_irq_enable;
        logic resume_detect_irq_enable;
        logic leg_event_output_enable;
        logic connect_change_wake_enable;
        logic remote_wake_enable;
    } uwcp_ctrl_t;

    // Core and port state mirrored by software
    typedef struct packed {
        logic [19:0] rsvd;
        logic port_resume;
        logic enh_idle;
        logic port_owner_enh;
        logic port_in_reset;
        logic ports_suspended;
        logic enhanced_halted_flag;
        logic [1:0] legacy_functional_state;
        logic [1:0] enh_pstate;
        logic [1:0] leg_pstate;
    } uwcp_pst_t;

    // Port events
    typedef struct packed {
        logic overcurrent;
        logic remote_wake;
        logic disconnect;
        logic connect;
    } uwcp_evt_t;

    // Clock stop levels
    typedef enum logic [1:0] {
        LVL_RUN = 2'b00,
        LVL_LOGIC_OFF = 2'b01,
        LVL_PLL_OFF = 2'b10,
        LVL_ALL_OFF = 2'b11
    } uwcp_lvl_t;

    // Clock-run line objection states
    typedef enum logic [1:0] {
        CR_IDLE = 2'b00,
        CR_DRIVE = 2'b01,
        CR_WAIT = 2'b10
    } uwcp_cr_t;
endpackage : uwcp_pkg

// file: logic/uwcp_top.sv
// Wake event, clock gating and clock-run control of the dual-core USB host
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps

module uwcp_top (
    input wire logic aclk, // System clock, 10 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic clock_source_select, // High selects 48 MHz oscillator
    input wire logic main_power_reset_in, // Main power reset pin
    input wire uwcp_pkg::uwcp_evt_t port_event_in, // Port event lines, async
    input wire logic pclk_in, // PCI clock, sampled
    input wire logic clock_run_line_in, // Clock-run line level
    output logic clock_run_line_out, // Clock-run drive value, always low
    output logic clock_run_line_oe_n, // Low while driving the line
    output logic pm_event_out, // Power-management event pin
    output logic irq_out, // Interrupt pin
    output logic logic_clk_en, // Internal logic clock gate
    output logic pll_en, // Analog PLL enable
    output logic osc_en // Internal oscillator enable
);
    localparam logic [4:0] WAKE_HOLD = 5'(uwcp_pkg::WAKE_HOLD_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [1:0] sel_sync_reg, mpr_sync_reg, pclk_sync_reg, crl_sync_reg;
    logic [3:0] evt_s1_reg, evt_s2_reg, evt_s3_reg;
    logic pclk_d_reg;

    // Two flops per external input, a third for edge detection
    always_ff @(posedge aclk) begin
        sel_sync_reg <= {sel_sync_reg[0], clock_source_select};
        mpr_sync_reg <= {mpr_sync_reg[0], main_power_reset_in};
        pclk_sync_reg <= {pclk_sync_reg[0], pclk_in};
        crl_sync_reg <= {crl_sync_reg[0], clock_run_line_in};
        evt_s1_reg <= port_event_in;
        evt_s2_reg <= evt_s1_reg;
        evt_s3_reg <= evt_s2_reg;
        pclk_d_reg <= pclk_sync_reg[1];
    end

    wire logic osc_mode = sel_sync_reg[1];
    wire logic mpr_high = mpr_sync_reg[1];
    wire logic pclk_rise = pclk_sync_reg[1] & ~pclk_d_reg;
    wire logic line_high = crl_sync_reg[1];
    wire uwcp_pkg::uwcp_evt_t evt_edge = uwcp_pkg::uwcp_evt_t'(evt_s2_reg & ~evt_s3_reg);

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    uwcp_pkg::uwcp_ctrl_t ctrl_reg;
    uwcp_pkg::uwcp_pst_t pst_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, status_word;

    // Byte-lane merge of a write onto a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // Decode of the write and read handshakes
    wire logic wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
    wire logic rd_go = s_axi_arvalid & ~rvalid_reg;
    wire logic wr_ctrl = wr_go & (s_axi_awaddr == uwcp_pkg::CTRL_OFFSET);
    wire logic wr_pst = wr_go & (s_axi_awaddr == uwcp_pkg::PSTATE_OFFSET);
    wire logic wr_stat = wr_go & (s_axi_awaddr == uwcp_pkg::STATUS_OFFSET);
    wire logic wr_op = wr_go & (s_axi_awaddr == uwcp_pkg::OPWRITE_OFFSET);
    wire logic wr_hit = wr_ctrl | wr_pst | wr_stat | wr_op;
    wire logic rd_hit = (s_axi_araddr == uwcp_pkg::CTRL_OFFSET) | (s_axi_araddr == uwcp_pkg::PSTATE_OFFSET)
                      | (s_axi_araddr == uwcp_pkg::STATUS_OFFSET) | (s_axi_araddr == uwcp_pkg::OPWRITE_OFFSET);
    wire logic [31:0] clr_mask = wr_stat ? merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb) : 32'h0000_0000;
    // Written words before trimming to the twelve live bits
    wire logic [31:0] ctrl_merged = merge(32'(ctrl_reg), s_axi_wdata, s_axi_wstrb);
    wire logic [31:0] pst_merged = merge(32'(pst_reg), s_axi_wdata, s_axi_wstrb);
    wire logic [31:0] rd_word = (s_axi_araddr == uwcp_pkg::CTRL_OFFSET) ? 32'(ctrl_reg)
                              : (s_axi_araddr == uwcp_pkg::PSTATE_OFFSET) ? 32'(pst_reg)
                              : (s_axi_araddr == uwcp_pkg::STATUS_OFFSET) ? status_word : 32'h0000_0000;

    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // Register writes and responses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= uwcp_pkg::uwcp_ctrl_t'(uwcp_pkg::CTRL_RESET);
            pst_reg <= uwcp_pkg::uwcp_pst_t'(uwcp_pkg::PSTATE_RESET);
            bvalid_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            bresp_reg <= uwcp_pkg::RESP_OKAY;
            rresp_reg <= uwcp_pkg::RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= uwcp_pkg::uwcp_ctrl_t'({20'h00000, ctrl_merged[11:0]});
            end
            if (wr_pst) begin
                pst_reg <= uwcp_pkg::uwcp_pst_t'({20'h00000, pst_merged[11:0]});
            end
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? uwcp_pkg::RESP_OKAY : uwcp_pkg::RESP_DECERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (rd_go) begin
                rvalid_reg <= 1'b1;
                rresp_reg <= rd_hit ? uwcp_pkg::RESP_OKAY : uwcp_pkg::RESP_DECERR;
                rdata_reg <= rd_word;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake event detection
    wire logic leg_port = ~pst_reg.port_owner_enh;
    wire logic leg_d0 = pst_reg.leg_pstate == uwcp_pkg::PS_D0;
    wire logic enh_d0 = pst_reg.enh_pstate == uwcp_pkg::PS_D0;
    // In port reset only over-current is seen
    wire logic det_conn = evt_edge.connect & ~pst_reg.port_in_reset;
    wire logic det_disc = evt_edge.disconnect & ~pst_reg.port_in_reset;
    wire logic det_rwk = evt_edge.remote_wake & ~pst_reg.port_in_reset;
    wire logic det_ovc = evt_edge.overcurrent;
    // Status flags are set by the enables in force when the event arrives
    wire logic leg_set = leg_port & ctrl_reg.remote_wake_enable
                       & (det_rwk | ((det_conn | det_disc) & ctrl_reg.connect_change_wake_enable));
    wire logic enh_set = ~leg_port & (det_rwk | (det_conn & ctrl_reg.connect_wake_enable)
                       | (det_disc & ctrl_reg.disconnect_wake_enable)
                       | (det_ovc & ctrl_reg.overcurrent_wake_enable));
    // Interrupt sources are only latched in full power
    wire logic leg_rwk_set = leg_port & leg_d0 & det_rwk;
    wire logic leg_cc_set = leg_port & leg_d0 & (det_conn | det_disc);
    wire logic enh_irq_set = ~leg_port & enh_d0 & (det_conn | det_disc | det_rwk | det_ovc);
    logic leg_flag_reg, enh_flag_reg, leg_rwk_reg, leg_cc_reg, enh_irq_reg;

    // Sticky flags; a set in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            leg_flag_reg <= 1'b0;
            enh_flag_reg <= 1'b0;
            leg_rwk_reg <= 1'b0;
            leg_cc_reg <= 1'b0;
            enh_irq_reg <= 1'b0;
        end else begin
            leg_flag_reg <= leg_set | (leg_flag_reg & ~clr_mask[0]);
            enh_flag_reg <= enh_set | (enh_flag_reg & ~clr_mask[1]);
            leg_rwk_reg <= leg_rwk_set | (leg_rwk_reg & ~clr_mask[2]);
            leg_cc_reg <= leg_cc_set | (leg_cc_reg & ~clr_mask[3]);
            enh_irq_reg <= enh_irq_set | (enh_irq_reg & ~clr_mask[4]);
        end
    end

    // Output enables act at output time, so late enables still report
    wire logic pme_next = (leg_flag_reg & ctrl_reg.leg_event_output_enable)
                        | (enh_flag_reg & ctrl_reg.enh_event_output_enable);
    wire logic leg_irq = leg_d0 & ((leg_rwk_reg & ctrl_reg.resume_detect_irq_enable)
                       | (leg_cc_reg & (ctrl_reg.hub_status_change_irq_enable
                       | (ctrl_reg.connect_change_wake_enable & ctrl_reg.resume_detect_irq_enable))));
    wire logic enh_irq = enh_d0 & enh_irq_reg & ctrl_reg.port_change_irq_enable;
    logic pme_reg, irq_reg;

    // Registered pins: disconnect flags and irq flags rise in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pme_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            pme_reg <= pme_next;
            irq_reg <= leg_irq | enh_irq;
        end
    end
    assign pm_event_out = pme_reg;
    assign irq_out = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Clock stop levels
    wire logic stop_ok = pst_reg.enhanced_halted_flag & pst_reg.ports_suspended
                       & ((pst_reg.legacy_functional_state == uwcp_pkg::LFS_SUSPEND)
                       | (pst_reg.legacy_functional_state == uwcp_pkg::LFS_RESET));
    wire logic both_d0 = leg_d0 & enh_d0;
    wire logic none_d0 = ~leg_d0 & ~enh_d0;
    uwcp_pkg::uwcp_lvl_t target, lvl_reg, target_d_reg;
    assign target = !stop_ok ? uwcp_pkg::LVL_RUN
                  : (mpr_high & both_d0) ? uwcp_pkg::LVL_LOGIC_OFF
                  : (mpr_high & none_d0) ? uwcp_pkg::LVL_PLL_OFF
                  : (~mpr_high & none_d0 & ~osc_mode) ? uwcp_pkg::LVL_ALL_OFF
                  : uwcp_pkg::LVL_RUN;
    logic halted_d_reg, lfs_op_d_reg;
    wire logic lfs_op = pst_reg.legacy_functional_state == uwcp_pkg::LFS_OPER;
    wire logic wake = (target != target_d_reg) | det_conn | det_disc | det_rwk
                    | (det_ovc & ctrl_reg.overcurrent_wake_enable)
                    | wr_op | (halted_d_reg & ~pst_reg.enhanced_halted_flag) | (lfs_op & ~lfs_op_d_reg);
    logic [4:0] hold_reg;

    // Level follows the target; a wake restarts and holds off re-stopping
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_reg <= uwcp_pkg::LVL_RUN;
            target_d_reg <= uwcp_pkg::LVL_RUN;
            halted_d_reg <= 1'b1;
            lfs_op_d_reg <= 1'b0;
            hold_reg <= 5'h00;
        end else begin
            target_d_reg <= target;
            halted_d_reg <= pst_reg.enhanced_halted_flag;
            lfs_op_d_reg <= lfs_op;
            if (wake) begin
                hold_reg <= WAKE_HOLD;
                lvl_reg <= uwcp_pkg::LVL_RUN;
            end else if (hold_reg != 5'h00) begin
                hold_reg <= hold_reg - 5'h01;
            end else begin
                lvl_reg <= target;
            end
        end
    end

    // PLL kept off in oscillator mode while the enhanced core is idle
    wire logic pll_idle_off = osc_mode & ~ctrl_reg.enh_run & pst_reg.enhanced_halted_flag & pst_reg.enh_idle
                            & pst_reg.port_owner_enh & ~pst_reg.port_in_reset & ~pst_reg.port_resume;
    logic logic_en_reg, pll_en_reg, osc_en_reg;

    // Gate enables come from flops so each changes once per edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            logic_en_reg <= 1'b1;
            pll_en_reg <= 1'b1;
            osc_en_reg <= 1'b1;
        end else begin
            logic_en_reg <= lvl_reg == uwcp_pkg::LVL_RUN;
            pll_en_reg <= (lvl_reg == uwcp_pkg::LVL_RUN || lvl_reg == uwcp_pkg::LVL_LOGIC_OFF) & ~pll_idle_off;
            osc_en_reg <= osc_mode | (lvl_reg != uwcp_pkg::LVL_ALL_OFF);
        end
    end
    assign logic_clk_en = logic_en_reg;
    assign pll_en = pll_en_reg;
    assign osc_en = osc_en_reg;

    ////////////////////////////////////////////////////////////////////////
    // Clock-run objection
    uwcp_pkg::uwcp_cr_t cr_reg;
    logic [1:0] edge_cnt_reg;
    wire logic need_pclk = ctrl_reg.legacy_bus_master | ctrl_reg.enh_run;
    wire logic driving = cr_reg == uwcp_pkg::CR_DRIVE;

    // Line high means a stop request; object by driving it low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cr_reg <= uwcp_pkg::CR_IDLE;
            edge_cnt_reg <= 2'h0;
        end else begin
            unique case (cr_reg)
                uwcp_pkg::CR_IDLE: begin
                    edge_cnt_reg <= 2'h0;
                    if (line_high & need_pclk) begin
                        cr_reg <= uwcp_pkg::CR_DRIVE;
                    end
                end
                uwcp_pkg::CR_DRIVE: begin
                    if (pclk_rise) begin
                        edge_cnt_reg <= edge_cnt_reg + 2'h1;
                        if (edge_cnt_reg + 2'h1 == uwcp_pkg::CLKRUN_HOLD_EDGES) begin
                            cr_reg <= uwcp_pkg::CR_WAIT;
                        end
                    end
                end
                uwcp_pkg::CR_WAIT: begin
                    if (!line_high) begin
                        cr_reg <= uwcp_pkg::CR_IDLE;
                    end
                end
                default: cr_reg <= uwcp_pkg::CR_IDLE;
            endcase
        end
    end
    assign clock_run_line_out = 1'b0;
    assign clock_run_line_oe_n = ~driving;

    assign status_word = {22'h000000, osc_en_reg, pll_en_reg, driving, lvl_reg,
                          enh_irq_reg, leg_cc_reg, leg_rwk_reg, enh_flag_reg, leg_flag_reg};

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_pme_or;
        pme_next |=> pm_event_out;
    endproperty
    a_pme_or: assert property (p_pme_or) else $error("event pin missed gated flag");

    property p_sticky;
        leg_flag_reg & ~clr_mask[0] |=> leg_flag_reg;
    endproperty
    a_sticky: assert property (p_sticky) else $error("event flag dropped without clear");

    property p_no_irq_low;
        !leg_d0 & !enh_d0 |=> !irq_out;
    endproperty
    a_no_irq_low: assert property (p_no_irq_low) else $error("irq in low power");

    property p_reset_only_ovc;
        pst_reg.port_in_reset & $stable(pst_reg) & !evt_edge.overcurrent & !leg_flag_reg |=> !leg_flag_reg;
    endproperty
    a_reset_only_ovc: assert property (p_reset_only_ovc) else $error("event seen in port reset");

    property p_late_wake;
        leg_port & !ctrl_reg.remote_wake_enable & !leg_flag_reg & !wr_stat |=> !leg_flag_reg;
    endproperty
    a_late_wake: assert property (p_late_wake) else $error("legacy flag set without wake enable");

    property p_stop_pre;
        !stop_ok ##1 !stop_ok |=> logic_clk_en;
    endproperty
    a_stop_pre: assert property (p_stop_pre) else $error("logic clock stopped without preconditions");

    property p_osc_run;
        osc_mode ##1 osc_mode |=> osc_en;
    endproperty
    a_osc_run: assert property (p_osc_run) else $error("oscillator stopped in oscillator mode");

    property p_wake_run;
        wake |=> ##1 logic_clk_en [*2];
    endproperty
    a_wake_run: assert property (p_wake_run) else $error("clocks not restarted on wake");

    property p_drive_hold;
        driving & !(pclk_rise & edge_cnt_reg == 2'h1) |=> driving;
    endproperty
    a_drive_hold: assert property (p_drive_hold) else $error("line released before second edge");

    property p_refuse;
        line_high & need_pclk & cr_reg == uwcp_pkg::CR_IDLE |=> driving;
    endproperty
    a_refuse: assert property (p_refuse) else $error("clock stop not refused");

    property p_release;
        driving & pclk_rise & edge_cnt_reg == 2'h1 |=> !driving;
    endproperty
    a_release: assert property (p_release) else $error("line held past second edge");

    c_pme: cover property (pme_next ##1 pm_event_out);
    c_irq: cover property (enh_irq ##1 irq_out);
    c_object: cover property ($rose(driving) ##[1:100] !driving);
    c_all_off: cover property (lvl_reg == uwcp_pkg::LVL_ALL_OFF);
endmodule : uwcp_top

// file: test/testbench.sv
// Self-checking bench for the wake and clock power control block
`timescale 1ns/1ps
module testbench;
    logic aclk, aresetn, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, stop_req, pclk, line, oe_n, pm, irq;
    logic lce, pll, osc, osc_sel, mpr;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic [1:0] bresp, rresp;
    uwcp_pkg::uwcp_evt_t ev;
    int n_mismatch = 0, n_compared = 0;
    uwcp_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .clock_source_select(osc_sel),
        .main_power_reset_in(mpr), .port_event_in(ev), .pclk_in(pclk), .clock_run_line_in(line),
        .clock_run_line_out(), .clock_run_line_oe_n(oe_n), .pm_event_out(pm), .irq_out(irq), .logic_clk_en(lce),
        .pll_en(pll), .osc_en(osc));
    uwcp_pcr u_pcr (.stop_req(stop_req), .dev_oe_n(oe_n), .pclk(pclk), .line(line));
    ////////////////////////////////////////////////////////////////////////
    // Verdict and comparison helpers
    task automatic wrap_up();
        if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Bounded wait: level seen settled mid-cycle, returns just after the edge that samples it
    task automatic wait_hi(ref logic s, input logic v);
        for (int i = 0; i < 400; i++) begin
            @(negedge aclk);
            if (s === v) break;
        end
        if (s !== v) begin
            n_mismatch++;
            wrap_up();
        end
        @(posedge aclk);
    endtask : wait_hi
    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite master cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        wait_hi(awr, 1'b1);
        awv <= 1'b0; wv <= 1'b0;
        wait_hi(bv, 1'b1);
        chk(bresp, r);
        br <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge aclk);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        wait_hi(arr, 1'b1);
        arv <= 1'b0;
        wait_hi(rv, 1'b1);
        chk(rresp, r);
        if (r == 2'h0) chk(rdat, e);
        rr <= 1'b0;
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs();
        rd(8'h04, 32'h40, 2'h0);
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h10, 32'h0, 2'h3);
        wr(8'h14, 32'h0, 2'h3);
    endtask : t_regs
    task automatic t_enh_disconnect();
        wr(8'h04, 32'h240, 2'h0);
        wr(8'h00, 32'h340, 2'h0);
        ev <= 4'h2;
        wait_hi(pm, 1'b1);
        chk(irq, 1'b1);
        ev <= 4'h0;
        wr(8'h08, 32'h1f, 2'h0);
        repeat (3) @(posedge aclk);
        chk(pm, 1'b0);
    endtask : t_enh_disconnect
    task automatic t_port_reset_and_sleep();
        wr(8'h04, 32'h340, 2'h0);
        ev <= 4'h2;
        repeat (8) @(posedge aclk);
        chk(pm, 1'b0);
        ev <= 4'h0;
        wr(8'h04, 32'h244, 2'h0);
        wr(8'h00, 32'h380, 2'h0);
        ev <= 4'h8;
        wait_hi(pm, 1'b1);
        chk(irq, 1'b0);
        ev <= 4'h0;
        wr(8'h08, 32'h1f, 2'h0);
    endtask : t_port_reset_and_sleep
    task automatic t_clock_run();
        stop_req <= 1'b1;
        repeat (20) @(posedge aclk);
        chk(oe_n, 1'b1);
        wr(8'h00, 32'h400, 2'h0);
        wait_hi(oe_n, 1'b0);
        wait_hi(oe_n, 1'b1);
        chk(oe_n, 1'b1);
        stop_req <= 1'b0;
    endtask : t_clock_run
    task automatic t_clock_stop();
        wr(8'h04, 32'hf0, 2'h0);
        wait_hi(lce, 1'b0);
        chk({pll, osc}, 2'h3);
        wr(8'h04, 32'hf5, 2'h0);
        wait_hi(pll, 1'b0);
        chk({lce, osc}, 2'h1);
        mpr <= 1'b0;
        wait_hi(osc, 1'b0);
        ev <= 4'h1;
        wait_hi(osc, 1'b1);
        ev <= 4'h0;
        wait_hi(osc, 1'b0);
        wr(8'h0c, 32'h0, 2'h0);
        wait_hi(osc, 1'b1);
        mpr <= 1'b1;
        osc_sel <= 1'b1;
        wr(8'h00, 32'h0, 2'h0);
        wr(8'h04, 32'h640, 2'h0);
        repeat (4) @(posedge aclk);
        chk({pll, osc}, 2'h1);
        wr(8'h00, 32'h400, 2'h0);
        repeat (2) @(posedge aclk);
        chk(pll, 1'b1);
    endtask : t_clock_stop
    ////////////////////////////////////////////////////////////////////////
    // Clock, reset and main sequence
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        {aresetn, awv, wv, br, arv, rr, stop_req, osc_sel, mpr} = 9'h001;
        ev = 4'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_enh_disconnect();
        t_port_reset_and_sleep();
        t_clock_run();
        t_clock_stop();
        wrap_up();
    end
endmodule : testbench

// file: test/uwcp_pcr.sv
// Central clock resource model: PCI clock and the clock-run wire
`timescale 1ns/1ps
module uwcp_pcr (
    input wire logic stop_req, // High: resource wants the PCI clock stopped
    input wire logic dev_oe_n, // Device drive enable, low while driving
    output logic pclk, // PCI clock, free-running; this model never stops it, refused or not
    output logic line // Resolved clock-run wire level
);
    logic hold_low = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // PCI clock, 800 ns period
    initial begin
        pclk = 1'b0;
        forever #400 pclk = ~pclk;
    end
    // Take the wire low on the first clock after the device objects, keep it low
    always @(posedge pclk) begin
        hold_low <= stop_req ? (hold_low | ~dev_oe_n) : 1'b0;
    end
    // Pull-up wins only while nobody drives low
    assign line = ~(~stop_req | hold_low | ~dev_oe_n);
endmodule : uwcp_pcr
